// ===== include/fetx_regs.vh
// Constants for the fast Ethernet transmit coding path
`ifndef FETX_REGS_VH
`define FETX_REGS_VH

// Control code-groups
`define FETX_SYM_I 5'h1F
`define FETX_SYM_J 5'h18
`define FETX_SYM_K 5'h11
`define FETX_SYM_T 5'h0D
`define FETX_SYM_R 5'h07
`define FETX_SYM_H 5'h04

// Nibbles that control groups stand for on decode: the start pair, then the rest
`define FETX_PRE_NIB 4'h5
`define FETX_ZERO_NIB 4'h0

// Rates and the derived bits per code-group
`define FETX_LINE_MBPS 125
`define FETX_DATA_MBPS 100
`define FETX_NIB_BITS 4
`define FETX_SYM_BITS (`FETX_NIB_BITS * `FETX_LINE_MBPS / `FETX_DATA_MBPS)
`define FETX_LAST_BIT 3'h4

// Scrambler
`define FETX_LFSR_W 11
`define FETX_TAP_HI 10
`define FETX_TAP_LO 8
`define FETX_LFSR_RST 11'h7FF

// MLT-3 level walk
`define FETX_MLT_ZERO_A 2'h0
`define FETX_MLT_PLUS 2'h1
`define FETX_MLT_ZERO_B 2'h2
`define FETX_MLT_MINUS 2'h3

// Nibble buffer
`define FETX_FIFO_WIDTH 5
`define FETX_FIFO_DEPTH 4
`define FETX_FIFO_AW 2

`endif

// ===== logic/fetx_fifo.v
// Small synchronous FIFO for MAC nibbles
`timescale 1ns/1ps
module fetx_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Full and empty come straight from the fill count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; nothing reads an empty slot
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap; depth is a power of two
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // fetx_fifo

// ===== logic/fetx_line.v
// Scrambler, NRZI encoder and MLT-3 drive splitter
`timescale 1ns/1ps
`include "fetx_regs.vh"
module fetx_line (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Serial code bits and options
  input wire nrz_bit,
  input wire scramble_bypass,
  input wire [4:0] phy_address_straps,
  // Line side
  output reg nrzi,
  output reg drive_pos,
  output reg drive_neg
);

  reg [`FETX_LFSR_W-1:0] lfsr;
  reg seeded;
  reg [1:0] level;
  wire feedback;
  wire line_bit;
  wire [1:0] next_level;

  // Feedback bit also serves as the key stream
  assign feedback = lfsr[`FETX_TAP_HI] ^ lfsr[`FETX_TAP_LO];
  assign line_bit = scramble_bypass ? nrz_bit : (nrz_bit ^ feedback);
  // A one moves the level one step round the walk
  assign next_level = line_bit ? level + 2'h1 : level;

  // Straps are caught at the first edge after release, not in reset;
  // the leading one keeps the seed away from the locked all-zero state
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lfsr <= `FETX_LFSR_RST;
      seeded <= 1'b0;
    end else if (!seeded) begin
      lfsr <= {1'b1, phy_address_straps, ~phy_address_straps};
      seeded <= 1'b1;
    end else begin
      lfsr <= {lfsr[`FETX_LFSR_W-2:0], feedback};
    end
  end

  // NRZI and the MLT-3 walk; only MLT-3 levels reach the pair
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nrzi <= 1'b0;
      level <= `FETX_MLT_ZERO_A;
      drive_pos <= 1'b0;
      drive_neg <= 1'b0;
    end else begin
      nrzi <= nrzi ^ line_bit;
      level <= next_level;
      drive_pos <= (next_level == `FETX_MLT_PLUS);
      drive_neg <= (next_level == `FETX_MLT_MINUS);
    end
  end

endmodule // fetx_line

// ===== logic/fetx_tx_path.v
// Transmit coding path: buffer, 4B/5B encoder, serializer, line stage
`timescale 1ns/1ps
`include "fetx_regs.vh"
module fetx_tx_path (
  // Clock and reset
  input wire clock,
  input wire rstn,

  // Nibble stream from the MAC
  input wire mac_tx_en,
  input wire [3:0] mac_txd,
  input wire mac_tx_valid,
  output wire mac_tx_ready,

  // Straps and options
  input wire [4:0] phy_address_straps,
  input wire scramble_bypass,

  // Line drive streams
  output wire tx_drive_pos,
  output wire tx_drive_neg,
  output wire tx_nrzi,

  // Code-group monitor
  output reg [4:0] tx_code_group,
  output reg tx_group_strobe,

  // Shared code table, receive side
  input wire [4:0] rx_group,
  input wire rx_group_valid,
  input wire rx_in_frame,
  output reg [3:0] rx_nibble,
  output reg rx_error,
  output reg rx_halt
);

  // Transmit sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_K = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_R = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] next_group;
  reg next_pop;
  reg [4:0] shifter;
  reg [2:0] bit_cnt;

  wire sym_load;
  wire buf_valid;
  wire [4:0] buf_word;
  wire buf_en;
  wire [3:0] buf_nib;
  wire [6:0] rx_dec;

  // Map one data nibble to its code-group
  function [4:0] fetx_enc;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: fetx_enc = 5'h1E;
        4'h1: fetx_enc = 5'h09;
        4'h2: fetx_enc = 5'h14;
        4'h3: fetx_enc = 5'h15;
        4'h4: fetx_enc = 5'h0A;
        4'h5: fetx_enc = 5'h0B;
        4'h6: fetx_enc = 5'h0E;
        4'h7: fetx_enc = 5'h0F;
        4'h8: fetx_enc = 5'h12;
        4'h9: fetx_enc = 5'h13;
        4'hA: fetx_enc = 5'h16;
        4'hB: fetx_enc = 5'h17;
        4'hC: fetx_enc = 5'h1A;
        4'hD: fetx_enc = 5'h1B;
        4'hE: fetx_enc = 5'h1C;
        default: fetx_enc = 5'h1D;
      endcase
    end
  endfunction

  // Decode a code-group to {invalid, halt, control, nibble}
  function [6:0] fetx_dec;
    input [4:0] grp;
    begin
      case (grp)
        5'h1E: fetx_dec = {3'h0, 4'h0};
        5'h09: fetx_dec = {3'h0, 4'h1};
        5'h14: fetx_dec = {3'h0, 4'h2};
        5'h15: fetx_dec = {3'h0, 4'h3};
        5'h0A: fetx_dec = {3'h0, 4'h4};
        5'h0B: fetx_dec = {3'h0, 4'h5};
        5'h0E: fetx_dec = {3'h0, 4'h6};
        5'h0F: fetx_dec = {3'h0, 4'h7};
        5'h12: fetx_dec = {3'h0, 4'h8};
        5'h13: fetx_dec = {3'h0, 4'h9};
        5'h16: fetx_dec = {3'h0, 4'hA};
        5'h17: fetx_dec = {3'h0, 4'hB};
        5'h1A: fetx_dec = {3'h0, 4'hC};
        5'h1B: fetx_dec = {3'h0, 4'hD};
        5'h1C: fetx_dec = {3'h0, 4'hE};
        5'h1D: fetx_dec = {3'h0, 4'hF};
        `FETX_SYM_I: fetx_dec = {3'h1, `FETX_ZERO_NIB};
        `FETX_SYM_T: fetx_dec = {3'h1, `FETX_ZERO_NIB};
        `FETX_SYM_R: fetx_dec = {3'h1, `FETX_ZERO_NIB};
        `FETX_SYM_J: fetx_dec = {3'h1, `FETX_PRE_NIB};
        `FETX_SYM_K: fetx_dec = {3'h1, `FETX_PRE_NIB};
        `FETX_SYM_H: fetx_dec = {3'h2, `FETX_ZERO_NIB};
        default: fetx_dec = {3'h4, `FETX_ZERO_NIB};
      endcase
    end
  endfunction

  // Enable travels with each nibble so framing stays in step with data
  fetx_fifo #(
    .WIDTH(`FETX_FIFO_WIDTH),
    .DEPTH(`FETX_FIFO_DEPTH),
    .AW(`FETX_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(mac_tx_valid),
    .in_data({mac_tx_en, mac_txd}),
    .in_ready(mac_tx_ready),
    .out_valid(buf_valid),
    .out_data(buf_word),
    .out_ready(next_pop)
  );

  assign buf_en = buf_word[4];
  assign buf_nib = buf_word[3:0];

  // A new code-group is taken on the last bit of the one in flight;
  // the buffer drains one nibble per five line bits, so it back-pressures
  assign sym_load = (bit_cnt == `FETX_LAST_BIT);

  // Choose the next code-group and whether a nibble is consumed
  always @* begin
    next_state = state;
    next_group = `FETX_SYM_I;
    next_pop = 1'b0;
    if (sym_load) begin
      case (state)
        ST_IDLE: begin
          if (buf_valid && buf_en) begin
            // First preamble nibble pair gives way to J then K
            next_group = `FETX_SYM_J;
            next_pop = 1'b1;
            next_state = ST_K;
          end else begin
            // Idle words from the MAC are consumed quietly
            next_group = `FETX_SYM_I;
            next_pop = buf_valid;
          end
        end
        ST_K: begin
          if (buf_valid && buf_en) begin
            next_group = `FETX_SYM_K;
            next_pop = 1'b1;
            next_state = ST_DATA;
          end else if (buf_valid) begin
            // Frame ended inside the preamble
            next_group = `FETX_SYM_T;
            next_pop = 1'b1;
            next_state = ST_R;
          end else begin
            // Underrun mid-frame cannot be hidden; flag it on the line
            next_group = `FETX_SYM_H;
          end
        end
        ST_DATA: begin
          if (buf_valid && buf_en) begin
            next_group = fetx_enc(buf_nib);
            next_pop = 1'b1;
          end else if (buf_valid) begin
            next_group = `FETX_SYM_T;
            next_pop = 1'b1;
            next_state = ST_R;
          end else begin
            next_group = `FETX_SYM_H;
          end
        end
        ST_R: begin
          // Buffer is left alone so a back-to-back frame is not lost
          next_group = `FETX_SYM_R;
          next_state = ST_IDLE;
        end
        default: begin
          next_group = `FETX_SYM_I;
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state advances only at code-group boundaries
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else if (sym_load) begin
      state <= next_state;
    end
  end

  // Serializer: leftmost code bit goes out first
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shifter <= `FETX_SYM_I;
      bit_cnt <= 3'h0;
    end else if (sym_load) begin
      shifter <= next_group;
      bit_cnt <= 3'h0;
    end else begin
      shifter <= {shifter[3:0], 1'b0};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Monitor copy of the group just loaded, strobed once per group
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_code_group <= `FETX_SYM_I;
      tx_group_strobe <= 1'b0;
    end else begin
      tx_group_strobe <= sym_load;
      if (sym_load) begin
        tx_code_group <= next_group;
      end
    end
  end

  // Line stage: scrambler, NRZI and MLT-3 split
  fetx_line u_line (
    .clock(clock),
    .rstn(rstn),
    .nrz_bit(shifter[4]),
    .scramble_bypass(scramble_bypass),
    .phy_address_straps(phy_address_straps),
    .nrzi(tx_nrzi),
    .drive_pos(tx_drive_pos),
    .drive_neg(tx_drive_neg)
  );

  assign rx_dec = fetx_dec(rx_group);

  // Receive decode; control groups inside a frame count as invalid
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_nibble <= 4'h0;
      rx_error <= 1'b0;
      rx_halt <= 1'b0;
    end else if (rx_group_valid) begin
      rx_nibble <= rx_dec[3:0];
      rx_halt <= rx_dec[5];
      rx_error <= rx_dec[6] | rx_dec[5] | (rx_dec[4] & rx_in_frame);
    end else begin
      rx_error <= 1'b0;
      rx_halt <= 1'b0;
    end
  end

endmodule // fetx_tx_path

// ===== tb/fetx_tx_path_sva.sv
// Port assertions for the transmit coding path
`timescale 1ns/1ps
`include "fetx_regs.vh"
module fetx_chk (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Line and monitor
  input wire tx_drive_pos,
  input wire tx_drive_neg,
  input wire tx_nrzi,
  input wire tx_group_strobe,
  input wire [4:0] tx_code_group,
  // Decode side
  input wire [4:0] rx_group,
  input wire rx_group_valid,
  input wire rx_in_frame,
  input wire [3:0] rx_nibble,
  input wire rx_error,
  input wire rx_halt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  reg last_pos;
  // Last nonzero level; a zero between two plus levels would hide a bad walk
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_pos <= 1'b0;
    end else if (tx_drive_pos) begin
      last_pos <= 1'b1;
    end else if (tx_drive_neg) begin
      last_pos <= 1'b0;
    end
  end
  property p_excl; !(tx_drive_pos && tx_drive_neg); endproperty
  a_excl: assert property (p_excl) else $error("both drives high");
  property p_pos; $rose(tx_drive_pos) |-> !last_pos; endproperty
  a_pos: assert property (p_pos) else $error("plus twice");
  property p_neg; $rose(tx_drive_neg) |-> last_pos; endproperty
  a_neg: assert property (p_neg) else $error("minus twice");
  property p_step; $changed(tx_nrzi) |-> ($changed(tx_drive_pos) != $changed(tx_drive_neg));
  endproperty
  a_step: assert property (p_step) else $error("no level step");
  property p_hold; $stable(tx_nrzi) |-> $stable(tx_drive_pos) && $stable(tx_drive_neg);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_rate; tx_group_strobe |=> !tx_group_strobe [*4] ##1 tx_group_strobe; endproperty
  a_rate: assert property (p_rate) else $error("group rate");
  property p_halt; rx_group_valid && rx_group == `FETX_SYM_H |=> rx_halt && rx_error;
  endproperty
  a_halt: assert property (p_halt) else $error("halt missed");
  property p_quiet; !rx_group_valid |=> !rx_error && !rx_halt; endproperty
  a_quiet: assert property (p_quiet) else $error("stray error");
  property p_ctl; rx_group_valid && rx_in_frame &&
    rx_group inside {5'h1F, 5'h18, 5'h11, 5'h0D, 5'h07} |=> rx_error; endproperty
  a_ctl: assert property (p_ctl) else $error("control in data");
  property p_zero; rx_group_valid && rx_group == 5'h1E |=> rx_nibble == 4'h0 && !rx_error;
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero");
  c_start: cover property (tx_group_strobe && tx_code_group == `FETX_SYM_J);
  c_halt: cover property (rx_halt);
  c_neg: cover property ($rose(tx_drive_neg));
endmodule // fetx_chk

bind fetx_tx_path fetx_chk fetx_chk_inst (.clock(clock), .rstn(rstn),
  .tx_drive_pos(tx_drive_pos), .tx_drive_neg(tx_drive_neg), .tx_nrzi(tx_nrzi),
  .tx_group_strobe(tx_group_strobe), .tx_code_group(tx_code_group),
  .rx_group(rx_group), .rx_group_valid(rx_group_valid), .rx_in_frame(rx_in_frame),
  .rx_nibble(rx_nibble), .rx_error(rx_error), .rx_halt(rx_halt));

// ===== tb/fetx_mac_model.sv
// MAC side model offering one frame of nibbles
`timescale 1ns/1ps
module fetx_mac_model (
  // Clock
  input wire clock,
  // Bench control
  input wire go,
  input wire [7:0] n_words,
  input wire [3:0] gap,
  output reg done,
  // Nibble stream
  output reg mac_tx_en,
  output reg [3:0] mac_txd,
  output reg mac_tx_valid,
  input wire mac_tx_ready
);
  integer i;
  integer g;
  initial begin
    done = 1'b1;
    mac_tx_en = 1'b0;
    mac_txd = 4'h0;
    mac_tx_valid = 1'b0;
  end
  // Enable held over the frame, one closing word with it low; gap makes it slow
  always @(posedge go) begin
    done = 1'b0;
    for (i = 0; i <= n_words; i = i + 1) begin
      @(negedge clock);
      mac_tx_en = (i < n_words);
      mac_txd = i[3:0];
      mac_tx_valid = 1'b1;
      while (!mac_tx_ready) @(negedge clock);
      @(posedge clock);
      for (g = 0; g < gap; g = g + 1) begin
        @(negedge clock);
        mac_tx_valid = 1'b0;
        mac_txd = ~mac_txd; // Released data does not keep its last value
      end
    end
    @(negedge clock);
    mac_tx_valid = 1'b0;
    mac_tx_en = 1'b0;
    done = 1'b1;
  end
endmodule // fetx_mac_model

// ===== tb/tb_fetx_tx_path.sv
// Self-checking bench for the transmit coding path
`timescale 1ns/1ps
`include "fetx_regs.vh"
module tb_fetx_tx_path;
  localparam [79:0] ENC = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
  // Rows: group, in frame, nibble, error, halt; row 0 sits in the low bits
  localparam [227:0] ROWS = {12'h602, 12'h402, 12'h302, 12'h282, 12'h182, 12'h102,
    12'h082, 12'h002, 12'h203, 12'h3C2, 12'h6C2, 12'h8C2, 12'hC42, 12'hFC2,
    12'h380, 12'h680, 12'h894, 12'hC14, 12'hF80};
  reg clock, rstn, bypass, rx_group_valid, rx_in_frame, go, saw_full;
  reg [4:0] straps, rx_group;
  reg [7:0] n_words;
  reg [3:0] gap;
  reg [11:0] r;
  reg [63:0] cap_a, cap_b;
  reg [4:0] q [0:255];
  wire en, valid, ready, done, pos, neg, nrzi, strobe, rx_error, rx_halt;
  wire [3:0] txd, rx_nibble;
  wire [4:0] code;
  integer failures, n_compared, nq, i, j, k, m;
  fetx_tx_path fetx_tx_path_inst (.clock(clock), .rstn(rstn), .mac_tx_en(en),
    .mac_txd(txd), .mac_tx_valid(valid), .mac_tx_ready(ready),
    .phy_address_straps(straps), .scramble_bypass(bypass), .tx_drive_pos(pos),
    .tx_drive_neg(neg), .tx_nrzi(nrzi), .tx_code_group(code), .tx_group_strobe(strobe),
    .rx_group(rx_group), .rx_group_valid(rx_group_valid), .rx_in_frame(rx_in_frame),
    .rx_nibble(rx_nibble), .rx_error(rx_error), .rx_halt(rx_halt));
  fetx_mac_model fetx_mac_model_inst (.clock(clock), .go(go), .n_words(n_words),
    .gap(gap), .done(done), .mac_tx_en(en), .mac_txd(txd), .mac_tx_valid(valid),
    .mac_tx_ready(ready));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Log of every strobed code-group, and whether the buffer ever refused
  always @(posedge clock) begin
    if (strobe && nq < 256) begin
      q[nq] = code;
      nq = nq + 1;
    end
    if (!ready) saw_full = 1'b1;
  end
  function [4:0] code_of(input [3:0] n);
    code_of = ENC[n*5 +: 5];
  endfunction
  task check(input [4:0] got, input [4:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task do_reset(input [4:0] s);
    begin
      @(negedge clock);
      rstn = 1'b0;
      straps = s;
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      nq = 0;
    end
  endtask
  task send(input [7:0] n, input [3:0] g);
    begin
      n_words = n;
      gap = g;
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      k = 0;
      while (!done && k < 3000) begin
        @(negedge clock);
        k = k + 1;
      end
      if (k >= 3000) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t frame never finished", $time);
      end
      repeat (60) @(negedge clock);
    end
  endtask
  task capture(input [4:0] s, input b, output [63:0] v);
    begin
      bypass = b;
      do_reset(s);
      for (i = 0; i < 64; i = i + 1) begin
        @(negedge clock);
        v[i] = nrzi;
        // Bypassed idle is all ones, so the level steps on every bit
        if (b) check({pos, neg}, {i[1:0] == 2'h0, i[1:0] == 2'h2});
      end
    end
  endtask
  // Cuts a hang short
  initial begin
    #400000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    {failures, n_compared, nq} = 0;
    {rstn, bypass, rx_group_valid, rx_in_frame, go, saw_full} = 6'h00;
    {straps, rx_group, n_words, gap} = 22'h0;
    do_reset(5'h0A);
    check(code, `FETX_SYM_I);
    check({strobe, pos, neg, nrzi, ready}, 5'h01);
    $display("reset done");
    // Decode table: control and invalid rows, then all data groups
    for (i = 0; i < 35; i = i + 1) begin
      j = i - 19;
      r = (i < 19) ? ROWS[i*12 +: 12] : {code_of(j[3:0]), j[0], j[3:0], 2'b00};
      rx_group = r[11:7];
      rx_in_frame = r[6];
      rx_group_valid = 1'b1;
      @(negedge clock);
      check(rx_error, r[1]);
      check(rx_halt, r[0]);
      if (!r[1]) check(rx_nibble, r[5:2]);
    end
    rx_group_valid = 1'b0;
    $display("decode table done");
    send(8'h12, 4'h0);
    j = 0;
    while (j < nq - 1 && q[j] === `FETX_SYM_I) j = j + 1;
    check(q[j], `FETX_SYM_J);
    check(q[j+1], `FETX_SYM_K);
    for (m = 2; m < 18; m = m + 1) check(q[j+m], code_of(m[3:0]));
    check(q[j+18], `FETX_SYM_T);
    check(q[j+19], `FETX_SYM_R);
    check(q[j+20], `FETX_SYM_I);
    check(q[nq-1], `FETX_SYM_I);
    check({saw_full, ready}, 5'h03);
    $display("frame done");
    nq = 0;
    send(8'h04, 4'hC);
    k = 0;
    for (m = 0; m < nq; m = m + 1) if (q[m] === `FETX_SYM_H) k = k + 1;
    check(k > 0, 1);
    j = nq - 1;
    while (j > 1 && q[j] === `FETX_SYM_I) j = j - 1;
    check(q[j-1], `FETX_SYM_T);
    check(q[j], `FETX_SYM_R);
    $display("underrun done");
    capture(5'h00, 1'b1, cap_a);
    for (i = 8; i < 64; i = i + 1) check(cap_a[i] ^ cap_a[i-1], 1);
    capture(5'h00, 1'b0, cap_b);
    check(cap_b[63:8] !== cap_a[63:8], 1);
    capture(5'h1F, 1'b0, cap_a);
    check(cap_a !== cap_b, 1);
    $display("line done");
    end_of_test;
  end
endmodule // tb_fetx_tx_path
